//--- rtl/sfc_map.vh
// Register map, field positions, reset values and bit timing for the
// serial format and control block. Holds definitions only.
`ifndef SFC_MAP_VH
`define SFC_MAP_VH

// Byte offsets on the register bus.
`define SFC_OFS_FORMAT  8'h00
`define SFC_OFS_CTRL    8'h04
`define SFC_OFS_FLAG    8'h08
`define SFC_OFS_TXHOLD  8'h0C
`define SFC_OFS_RXHOLD  8'h10
`define SFC_OFS_RATE    8'h14
`define SFC_OFS_TIMER   8'h18

// Field positions in serial_format_reg.
`define SFC_FMT_SYNC    7
`define SFC_FMT_CHR7    6
`define SFC_FMT_PAR     5
`define SFC_FMT_ODD     4
`define SFC_FMT_STOP2   3
`define SFC_FMT_MP      2
`define SFC_FMT_CKS_HI  1
`define SFC_FMT_CKS_LO  0

// Field positions in serial_ctrl_reg.
`define SFC_CTL_TXE_IE  7
`define SFC_CTL_RX_IE   6
`define SFC_CTL_XMIT    5
`define SFC_CTL_RCV     4
`define SFC_CTL_GATE    3
`define SFC_CTL_TXD_IE  2

// Field positions in serial_flag_reg.
`define SFC_FLG_TXEMPTY 7
`define SFC_FLG_RXFULL  6
`define SFC_FLG_OVR     5
`define SFC_FLG_FRM     4
`define SFC_FLG_PAR     3
`define SFC_FLG_TXDONE  2
`define SFC_FLG_MPB     1
`define SFC_FLG_MPBT    0

// Field position in shared_timer_ctrl_reg.
`define SFC_TMR_MPE     0

// Reset values.
`define SFC_RST_FORMAT  8'h00
`define SFC_RST_CTRL    8'h00
`define SFC_RST_FLAG    8'h84
`define SFC_RST_TXHOLD  8'hFF
`define SFC_RST_RXHOLD  8'h00
`define SFC_RST_RATE    8'hFF
`define SFC_RST_TIMER   8'h00

// Baud ticks per bit: sample point and last tick of a bit.
`define SFC_ASYNC_HALF  4'h7
`define SFC_ASYNC_FULL  4'hF
`define SFC_SYNC_HALF   4'h0
`define SFC_SYNC_FULL   4'h1

`endif

//--- rtl/sfc_baud.v
// Baud tick generator: prescaler followed by a reloading rate counter.
// Assumes one clock; reset and clock enable come from the top level.
`timescale 1ns/10ps
`default_nettype none
module sfc_baud
(
  // Clock and control
  input  wire       clk,
  input  wire       rst,
  input  wire       ce,
  // Settings
  input  wire [1:0] presc,
  input  wire [7:0] rate,
  // Output
  output reg        tick
);

  reg  [5:0] pre;
  reg  [7:0] cnt;
  wire       pre_en;

  // Codes 01, 10 and 11 divide by 4, 16 and 64.
  assign pre_en = (presc == 2'h0) ? 1'b1 :
                  (presc == 2'h1) ? &pre[1:0] :
                  (presc == 2'h2) ? &pre[3:0] : &pre;

  always @(posedge clk)
  begin
    if (rst)
    begin
      pre  <= 6'h00;
      cnt  <= 8'h00;
      tick <= 1'b0;
    end
    else if (ce)
    begin
      pre  <= pre + 6'h01;
      tick <= 1'b0;
      if (pre_en)
      begin
        if (cnt == 8'h00)
        begin
          cnt  <= rate;
          tick <= 1'b1;
        end
        else
          cnt <= cnt - 8'h01;
      end
    end
  end

endmodule // sfc_baud
`default_nettype wire

//--- rtl/sfc_top.v
// Serial channel with format and control registers behind an APB slave.
// Assumes one clock, a synchronous reset, and a peer on the serial pins.
`timescale 1ns/10ps
`default_nettype none
`include "sfc_map.vh"
module sfc_top
(
  // Clock, reset and power state
  input  wire        CORE_CLK,
  input  wire        SYS_RST,
  input  wire        CLK_EN,
  input  wire        STANDBY,
  // APB slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  // Serial pins
  input  wire        SERIAL_IN,
  output reg         SERIAL_OUT,
  output reg         SERIAL_OUT_OE,
  output reg         SERIAL_IN_OWNED,
  output reg         SCK_OUT,
  output reg         SCK_OE,
  // Interrupt requests
  output reg         TX_EMPTY_IRQ,
  output reg         RX_FULL_IRQ,
  output reg         RX_ERROR_IRQ,
  output reg         TX_END_IRQ
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_START = 3'h1;
  localparam [2:0] ST_DATA  = 3'h2;
  localparam [2:0] ST_EXTRA = 3'h3;
  localparam [2:0] ST_STOP  = 3'h4;

  // Parity bit that makes data plus parity even, or odd when odd is set.
  function par_bit;
    input [7:0] d;
    input       odd;
    begin
      par_bit = (^d) ^ odd;
    end
  endfunction

  wire       rst = SYS_RST | STANDBY;

  // Registers.
  reg  [7:0] fmt;
  reg  [7:0] ctl;
  reg  [7:0] rate;
  reg        global_multiproc_en;
  reg  [7:0] tx_hold;
  reg  [7:0] rx_hold;
  reg        tx_empty;
  reg        rx_full;
  reg        ovr;
  reg        frm;
  reg        perr;
  reg        tx_done;
  reg        rx_mpb;
  reg        tx_mpbt;

  // Transmitter state.
  reg  [2:0] tx_st;
  reg  [3:0] tx_cnt;
  reg  [2:0] tx_bit;
  reg  [7:0] tx_sh;
  reg        tx_x;
  reg        tx_stp;

  // Receiver state and input synchroniser.
  reg  [2:0] rx_st;
  reg  [3:0] rx_cnt;
  reg  [2:0] rx_bit;
  reg  [7:0] rx_sh;
  reg        rx_x;
  reg        rx_s1;
  reg        rx_s2;
  reg        rx_s3;
  reg        lvl;

  wire       tick;

  // Mode decode.
  wire sync_md = fmt[`SFC_FMT_SYNC];
  wire chr7    = fmt[`SFC_FMT_CHR7] & ~sync_md;
  wire mp_act  = global_multiproc_en & fmt[`SFC_FMT_MP] & ~sync_md;
  wire par_on  = fmt[`SFC_FMT_PAR] & ~mp_act & ~sync_md;
  wire odd     = fmt[`SFC_FMT_ODD];
  wire stop2   = fmt[`SFC_FMT_STOP2] & ~sync_md;
  wire xmit_on = ctl[`SFC_CTL_XMIT];
  wire rcv_on  = ctl[`SFC_CTL_RCV];
  wire gate    = ctl[`SFC_CTL_GATE] & mp_act;
  wire has_x   = ~sync_md & (mp_act | par_on);
  wire [2:0] nb_m1 = chr7 ? 3'h6 : 3'h7;
  wire [3:0] half  = sync_md ? `SFC_SYNC_HALF : `SFC_ASYNC_HALF;
  wire [3:0] full  = sync_md ? `SFC_SYNC_FULL : `SFC_ASYNC_FULL;
  wire [7:0] dmask = chr7 ? 8'h7F : 8'hFF;

  // Bus decode. A write lands on the edge that samples PREADY high.
  wire acc    = PSEL & PENABLE;
  wire wr_go  = acc & PWRITE & PREADY;
  wire wr_fmt = wr_go & (PADDR == `SFC_OFS_FORMAT);
  wire wr_ctl = wr_go & (PADDR == `SFC_OFS_CTRL);
  wire wr_flg = wr_go & (PADDR == `SFC_OFS_FLAG);
  wire wr_txh = wr_go & (PADDR == `SFC_OFS_TXHOLD);
  wire wr_rat = wr_go & (PADDR == `SFC_OFS_RATE);
  wire wr_tmr = wr_go & (PADDR == `SFC_OFS_TIMER);
  wire clr_te = wr_flg & ~PWDATA[`SFC_FLG_TXEMPTY];
  wire clr_rf = wr_flg & ~PWDATA[`SFC_FLG_RXFULL];
  wire clr_ov = wr_flg & ~PWDATA[`SFC_FLG_OVR];
  wire clr_fr = wr_flg & ~PWDATA[`SFC_FLG_FRM];
  wire clr_pe = wr_flg & ~PWDATA[`SFC_FLG_PAR];

  // Transmit events.
  wire tx_tk   = tick & (tx_cnt == full);
  wire tx_load = xmit_on & (tx_st == ST_IDLE) & ~tx_empty;
  wire tx_fin  = xmit_on & tx_tk &
                 (((tx_st == ST_STOP) & ~tx_stp) |
                  ((tx_st == ST_DATA) & sync_md & (tx_bit == nb_m1)));
  wire [7:0] tx_dat = tx_hold & dmask;

  // Receive events.
  wire rx_tk   = tick & (rx_cnt == full);
  wire rx_smp  = tick & (rx_cnt == half);
  wire rx_fin  = rcv_on & rx_smp &
                 ((rx_st == ST_STOP) |
                  ((rx_st == ST_DATA) & sync_md & (rx_bit == 3'h7)));
  wire [7:0] rx_dat = sync_md ? {lvl, rx_sh[7:1]} :
                      (chr7 ? {1'b0, rx_sh[7:1]} : rx_sh);
  wire rx_ferr = ~sync_md & ~lvl;
  wire rx_perr = par_on & (rx_x != par_bit(rx_dat, odd));
  wire rx_drop = gate & ~rx_x;
  wire rx_addr = gate & rx_x;
  wire rx_take = rx_fin & ~rx_drop;

  reg  [7:0] rd_val;
  reg        rd_ok;

  always @*
  begin
    rd_ok  = 1'b1;
    rd_val = 8'h00;
    case (PADDR)
      `SFC_OFS_FORMAT: rd_val = fmt;
      `SFC_OFS_CTRL:   rd_val = ctl;
      `SFC_OFS_FLAG:   rd_val = {tx_empty, rx_full, ovr, frm, perr,
                                 tx_done, rx_mpb, tx_mpbt};
      `SFC_OFS_TXHOLD: rd_val = tx_hold;
      `SFC_OFS_RXHOLD: rd_val = rx_hold;
      `SFC_OFS_RATE:   rd_val = rate;
      `SFC_OFS_TIMER:  rd_val = {7'h00, global_multiproc_en};
      default:         rd_ok  = 1'b0;
    endcase
  end

  // APB answer: one wait state, then PREADY for one cycle.
  always @(posedge CORE_CLK)
  begin
    if (rst)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
    end
    else if (CLK_EN)
    begin
      PREADY  <= acc & ~PREADY;
      PSLVERR <= acc & ~PREADY & ~rd_ok;
      if (acc & ~PREADY & ~PWRITE)
        PRDATA <= {24'h000000, rd_val};
    end
  end

  // Software registers and status flags. Hardware sets win over clears.
  always @(posedge CORE_CLK)
  begin
    if (rst)
    begin
      fmt      <= `SFC_RST_FORMAT;
      ctl      <= `SFC_RST_CTRL;
      rate     <= `SFC_RST_RATE;
      global_multiproc_en      <= 1'b0;
      tx_hold  <= `SFC_RST_TXHOLD;
      rx_hold  <= `SFC_RST_RXHOLD;
      tx_empty <= 1'b1;
      rx_full  <= 1'b0;
      ovr      <= 1'b0;
      frm      <= 1'b0;
      perr     <= 1'b0;
      tx_done  <= 1'b1;
      rx_mpb   <= 1'b0;
      tx_mpbt  <= 1'b0;
    end
    else if (CLK_EN)
    begin
      if (wr_fmt)
        fmt <= PWDATA[7:0];
      if (wr_rat)
        rate <= PWDATA[7:0];
      if (wr_tmr)
        global_multiproc_en <= PWDATA[`SFC_TMR_MPE];
      if (wr_txh)
        tx_hold <= PWDATA[7:0];
      if (wr_flg)
        tx_mpbt <= PWDATA[`SFC_FLG_MPBT];
      // An address frame clears the gate even during a control write.
      if (wr_ctl)
        ctl <= PWDATA[7:0];
      if (rx_take & rx_addr)
        ctl[`SFC_CTL_GATE] <= 1'b0;
      tx_empty <= (tx_empty & ~clr_te) | tx_load | ~xmit_on;
      tx_done  <= (tx_done & ~clr_te) | ~xmit_on |
                  (tx_fin & tx_empty);
      rx_full  <= (rx_full & ~clr_rf) |
                  (rx_take & ~rx_full & ~rx_ferr & ~rx_perr);
      ovr      <= (ovr & ~clr_ov) | (rx_take & rx_full);
      frm      <= (frm & ~clr_fr) | (rx_take & rx_ferr);
      perr     <= (perr & ~clr_pe) | (rx_take & rx_perr);
      if (rx_take & ~rx_full)
        rx_hold <= rx_dat;
      if (rx_take & mp_act)
        rx_mpb <= rx_x;
    end
  end

  // Transmitter. The line idles high; in sync mode it holds the last bit.
  always @(posedge CORE_CLK)
  begin
    if (rst)
    begin
      tx_st      <= ST_IDLE;
      tx_cnt     <= 4'h0;
      tx_bit     <= 3'h0;
      tx_sh      <= 8'h00;
      tx_x       <= 1'b0;
      tx_stp     <= 1'b0;
      SERIAL_OUT <= 1'b1;
    end
    else if (CLK_EN)
    begin
      if (!xmit_on)
      begin
        tx_st      <= ST_IDLE;
        SERIAL_OUT <= 1'b1;
      end
      else if (tx_load)
      begin
        tx_sh      <= tx_dat;
        tx_x       <= mp_act ? tx_mpbt : par_bit(tx_dat, odd);
        tx_cnt     <= 4'h0;
        tx_bit     <= 3'h0;
        tx_st      <= sync_md ? ST_DATA : ST_START;
        SERIAL_OUT <= sync_md ? tx_dat[0] : 1'b0;
      end
      else if (tx_st != ST_IDLE && tick)
      begin
        tx_cnt <= tx_tk ? 4'h0 : tx_cnt + 4'h1;
        if (tx_tk)
        begin
          case (tx_st)
            ST_START:
            begin
              tx_st      <= ST_DATA;
              SERIAL_OUT <= tx_sh[0];
            end
            ST_DATA:
            begin
              if (tx_bit != nb_m1)
              begin
                tx_bit     <= tx_bit + 3'h1;
                tx_sh      <= {1'b0, tx_sh[7:1]};
                SERIAL_OUT <= tx_sh[1];
              end
              else if (sync_md)
                tx_st <= ST_IDLE;
              else if (has_x)
              begin
                tx_st      <= ST_EXTRA;
                SERIAL_OUT <= tx_x;
              end
              else
              begin
                tx_st      <= ST_STOP;
                tx_stp     <= stop2;
                SERIAL_OUT <= 1'b1;
              end
            end
            ST_EXTRA:
            begin
              tx_st      <= ST_STOP;
              tx_stp     <= stop2;
              SERIAL_OUT <= 1'b1;
            end
            ST_STOP:
            begin
              if (tx_stp)
                tx_stp <= 1'b0;
              else
                tx_st <= ST_IDLE;
            end
            default:
              tx_st <= ST_IDLE;
          endcase
        end
      end
    end
  end

  // Receiver. The pin passes three flops; a change counts once the last
  // two agree, so a single-cycle glitch never reaches the frame logic.
  always @(posedge CORE_CLK)
  begin
    if (rst)
    begin
      rx_s1  <= 1'b1;
      rx_s2  <= 1'b1;
      rx_s3  <= 1'b1;
      lvl    <= 1'b1;
      rx_st  <= ST_IDLE;
      rx_cnt <= 4'h0;
      rx_bit <= 3'h0;
      rx_sh  <= 8'h00;
      rx_x   <= 1'b0;
    end
    else if (CLK_EN)
    begin
      rx_s1 <= SERIAL_IN;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_s2 == rx_s3)
        lvl <= rx_s3;
      if (!rcv_on)
        rx_st <= ST_IDLE;
      else if (rx_st == ST_IDLE)
      begin
        rx_cnt <= 4'h0;
        rx_bit <= 3'h0;
        if (sync_md)
          rx_st <= ST_DATA;
        else if (!lvl)
          rx_st <= ST_START;
      end
      else if (tick)
      begin
        rx_cnt <= rx_tk ? 4'h0 : rx_cnt + 4'h1;
        case (rx_st)
          ST_START:
          begin
            if (rx_smp && lvl)
              rx_st <= ST_IDLE;
            else if (rx_tk)
              rx_st <= ST_DATA;
          end
          ST_DATA:
          begin
            if (rx_smp)
              rx_sh <= {lvl, rx_sh[7:1]};
            if (rx_fin)
              rx_st <= ST_IDLE;
            else if (rx_tk && rx_bit != nb_m1)
              rx_bit <= rx_bit + 3'h1;
            else if (rx_tk)
              rx_st <= has_x ? ST_EXTRA : ST_STOP;
          end
          ST_EXTRA:
          begin
            if (rx_smp)
              rx_x <= lvl;
            if (rx_tk)
              rx_st <= ST_STOP;
          end
          ST_STOP:
          begin
            // Only the first stop is checked; idle hunting then takes a
            // low second stop as the next start bit.
            if (rx_smp)
              rx_st <= ST_IDLE;
          end
          default:
            rx_st <= ST_IDLE;
        endcase
      end
    end
  end

  // Pin ownership, serial clock and interrupt requests.
  always @(posedge CORE_CLK)
  begin
    if (rst)
    begin
      SERIAL_OUT_OE   <= 1'b0;
      SERIAL_IN_OWNED <= 1'b0;
      SCK_OUT         <= 1'b1;
      SCK_OE          <= 1'b0;
      TX_EMPTY_IRQ    <= 1'b0;
      RX_FULL_IRQ     <= 1'b0;
      RX_ERROR_IRQ    <= 1'b0;
      TX_END_IRQ      <= 1'b0;
    end
    else if (CLK_EN)
    begin
      SERIAL_OUT_OE   <= xmit_on;
      SERIAL_IN_OWNED <= rcv_on;
      SCK_OE          <= sync_md & (xmit_on | rcv_on);
      // The clock is high in the second half of each synchronous bit.
      if (xmit_on && tx_st != ST_IDLE)
        SCK_OUT <= (tx_cnt == `SFC_SYNC_FULL);
      else if (rcv_on && rx_st != ST_IDLE)
        SCK_OUT <= (rx_cnt == `SFC_SYNC_FULL);
      else
        SCK_OUT <= 1'b1;
      TX_EMPTY_IRQ <= ctl[`SFC_CTL_TXE_IE] & tx_empty;
      RX_FULL_IRQ  <= ctl[`SFC_CTL_RX_IE] & rx_full;
      RX_ERROR_IRQ <= ctl[`SFC_CTL_RX_IE] & (ovr | frm | perr);
      TX_END_IRQ   <= ctl[`SFC_CTL_TXD_IE] & tx_done;
    end
  end

  sfc_baud u_baud
  (
    .clk   (CORE_CLK),
    .rst   (rst),
    .ce    (CLK_EN),
    .presc (fmt[`SFC_FMT_CKS_HI:`SFC_FMT_CKS_LO]),
    .rate  (rate),
    .tick  (tick)
  );

endmodule // sfc_top
`default_nettype wire

//--- sim/sfc_chk.sv
// Checker for sfc_top: bus handshake, pin ownership, request gating.
// Assumes CLK_EN is held high, so that every clock edge counts.
`timescale 1ns/10ps
`default_nettype none
`include "sfc_map.vh"
module sfc_chk
(
  // Clock and resets
  input wire logic        CORE_CLK,
  input wire logic        SYS_RST,
  input wire logic        STANDBY,
  // Register bus
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Pins and requests
  input wire logic        SERIAL_OUT,
  input wire logic        SERIAL_OUT_OE,
  input wire logic        SERIAL_IN_OWNED,
  input wire logic        SCK_OE,
  input wire logic        TX_EMPTY_IRQ,
  input wire logic        RX_FULL_IRQ,
  input wire logic        RX_ERROR_IRQ,
  input wire logic        TX_END_IRQ
);
  // Shadow copies; hardware may clear the gate bit, so bit 3 is not used.
  logic [7:0] ctrl;
  logic [7:0] fmt;
  logic       wr;
  assign wr = PSEL && PENABLE && PREADY && PWRITE;
  always @(posedge CORE_CLK)
  begin
    if (SYS_RST || STANDBY)
    begin
      ctrl <= 8'h00;
      fmt  <= 8'h00;
    end
    else if (wr && PADDR == `SFC_OFS_CTRL)
      ctrl <= PWDATA[7:0];
    else if (wr && PADDR == `SFC_OFS_FORMAT)
      fmt <= PWDATA[7:0];
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST || STANDBY);
  property p_wait; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
  a_wait: assert property (p_wait) else $error("ready late");
  property p_pulse; $rose(PREADY) |=> !PREADY; endproperty
  a_pulse: assert property (p_pulse) else $error("ready long");
  property p_err; PSLVERR |-> PREADY && PSEL && PENABLE; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_idle; $fell(SYS_RST) |-> SERIAL_OUT && !SERIAL_OUT_OE; endproperty
  a_idle: assert property (p_idle) else $error("not idle");
  // Reset clears the pin outputs at once, on the same edge as the shadow.
  property p_out_oe;
    SERIAL_OUT_OE == ($past(SYS_RST || STANDBY) ? 1'b0 : $past(ctrl[5]));
  endproperty
  a_out_oe: assert property (p_out_oe) else $error("tx pin");
  property p_in_own;
    SERIAL_IN_OWNED == ($past(SYS_RST || STANDBY) ? 1'b0 : $past(ctrl[4]));
  endproperty
  a_in_own: assert property (p_in_own) else $error("rx pin");
  property p_sck;
    SCK_OE == ($past(SYS_RST || STANDBY) ? 1'b0 :
               $past(fmt[7] && (ctrl[5] || ctrl[4])));
  endproperty
  a_sck: assert property (p_sck) else $error("clock pin");
  property p_txe; TX_EMPTY_IRQ |-> $past(ctrl[7]); endproperty
  a_txe: assert property (p_txe) else $error("empty req");
  property p_rx; RX_FULL_IRQ || RX_ERROR_IRQ |-> $past(ctrl[6]); endproperty
  a_rx: assert property (p_rx) else $error("rx req");
  property p_tx_done_flag; TX_END_IRQ |-> $past(ctrl[2]); endproperty
  a_tx_done_flag: assert property (p_tx_done_flag) else $error("end req");
  property p_mark; !SERIAL_OUT_OE && !$past(SERIAL_OUT_OE) |-> SERIAL_OUT;
  endproperty
  a_mark: assert property (p_mark) else $error("line low");
  c_ctrl: cover property (wr && PADDR == `SFC_OFS_CTRL);
  c_tx_done_flag: cover property ($rose(TX_END_IRQ));
  c_err: cover property ($rose(RX_ERROR_IRQ));
endmodule // sfc_chk
bind sfc_top sfc_chk u_chk (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
  .STANDBY(STANDBY), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SERIAL_OUT(SERIAL_OUT), .SERIAL_OUT_OE(SERIAL_OUT_OE),
  .SERIAL_IN_OWNED(SERIAL_IN_OWNED), .SCK_OE(SCK_OE),
  .TX_EMPTY_IRQ(TX_EMPTY_IRQ), .RX_FULL_IRQ(RX_FULL_IRQ),
  .RX_ERROR_IRQ(RX_ERROR_IRQ), .TX_END_IRQ(TX_END_IRQ));
`default_nettype wire

//--- sim/sfc_peer.sv
// Peer serial device: sends frames to the block, captures its frames.
// Assumes BIT clocks per bit; callers enter right after a clock edge.
`timescale 1ns/10ps
`default_nettype none
module sfc_peer
#(
  parameter int BIT = 16
)
(
  // Clock
  input wire logic clk,
  // Line from the block, line to the block
  input wire logic line_in,
  output var logic line_out
);
  // The link idles at mark, as a pulled-up line does.
  initial line_out = 1'b1;
  // Start bit, then n caller-built bits LSB first, then mark again.
  task automatic send(input logic [11:0] b, input int n);
    line_out <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      line_out <= b[i];
      repeat (BIT) @(posedge clk);
    end
    line_out <= 1'b1;
  endtask
  // Samples n bits mid-bit from the start edge; b[0] is the start bit.
  task automatic grab(input int n, output logic [11:0] b);
    b = 12'h000;
    @(negedge line_in);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      b[i] = line_in;
      repeat (BIT) @(posedge clk);
    end
  endtask
endmodule // sfc_peer
`default_nettype wire

//--- sim/tb.sv
// Bench for sfc_top: registers over the bus, frames in both directions.
// Assumes the peer model and the bound checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`include "sfc_map.vh"
module tb;
  localparam int BIT = 16;
  logic        CORE_CLK = 1'b0;
  logic        SYS_RST  = 1'b1;
  logic        STANDBY  = 1'b0;
  logic        PSEL     = 1'b0;
  logic        PENABLE  = 1'b0;
  logic        PWRITE   = 1'b0;
  logic [7:0]  PADDR    = 8'h00;
  logic [31:0] PWDATA   = 32'h0;
  logic [31:0] PRDATA, rd;
  logic        PREADY, PSLVERR, SERIAL_IN, SERIAL_OUT, SERIAL_OUT_OE;
  logic        SERIAL_IN_OWNED, SCK_OE, TX_EMPTY_IRQ, TX_END_IRQ;
  logic        RX_FULL_IRQ, RX_ERROR_IRQ, tx_wire, SCK_OUT;
  int          fail_count = 0;
  int          n_compared = 0;
  // A released transmit pin floats to the pulled-up mark level.
  assign tx_wire = SERIAL_OUT_OE ? SERIAL_OUT : 1'b1;
  always #2.5 CORE_CLK = ~CORE_CLK;
  sfc_top dut (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CLK_EN(1'b1),
    .STANDBY(STANDBY), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SERIAL_IN(SERIAL_IN), .SERIAL_OUT(SERIAL_OUT),
    .SERIAL_OUT_OE(SERIAL_OUT_OE), .SERIAL_IN_OWNED(SERIAL_IN_OWNED),
    .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE), .TX_EMPTY_IRQ(TX_EMPTY_IRQ),
    .RX_FULL_IRQ(RX_FULL_IRQ), .RX_ERROR_IRQ(RX_ERROR_IRQ),
    .TX_END_IRQ(TX_END_IRQ));
  sfc_peer #(.BIT(BIT)) peer (.clk(CORE_CLK), .line_in(tx_wire),
    .line_out(SERIAL_IN));
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge CORE_CLK);
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge CORE_CLK);
      k++;
    end
    while (PREADY !== 1'b1 && k < 40);
    rd = PRDATA;
    check("pready", {31'h0, PREADY}, 32'h1);
    check("slverr", {31'h0, PSLVERR}, {31'h0, a > 8'h18});
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask
  task automatic settle();
    repeat (3) @(posedge CORE_CLK);
  endtask
  task automatic cfg(input logic [7:0] f, input logic m, input logic [7:0] c);
    wr(`SFC_OFS_RATE, 32'h0);
    wr(`SFC_OFS_FORMAT, {24'h0, f});
    wr(`SFC_OFS_TIMER, {31'h0, m});
    wr(`SFC_OFS_CTRL, {24'h0, c});
  endtask
  task automatic rxf(input logic [11:0] b, input int n);
    @(posedge CORE_CLK);
    peer.send(b, n);
    repeat (2 * BIT) @(posedge CORE_CLK);
  endtask
  task automatic t_regs();
    check("sck_idle", {31'h0, SCK_OUT}, 32'h1);
    rdc("format", `SFC_OFS_FORMAT, 32'h0);
    rdc("ctrl", `SFC_OFS_CTRL, 32'h0);
    rdc("flag", `SFC_OFS_FLAG, 32'h84);
    rdc("unmapped", 8'h1C, 32'h0);
    wr(`SFC_OFS_CTRL, 32'hFFFF_FFA5);
    rdc("ctrl", `SFC_OFS_CTRL, 32'hA5);
    check("txe_irq", {31'h0, TX_EMPTY_IRQ}, 32'h1);
    check("out_oe", {31'h0, SERIAL_OUT_OE}, 32'h1);
    wr(`SFC_OFS_CTRL, 32'h5A);
    rdc("ctrl", `SFC_OFS_CTRL, 32'h5A);
    check("txe_irq", {31'h0, TX_EMPTY_IRQ}, 32'h0);
    check("in_owned", {31'h0, SERIAL_IN_OWNED}, 32'h1);
    wr(`SFC_OFS_FORMAT, 32'h80);
    settle();
    check("sck_oe", {31'h0, SCK_OE}, 32'h1);
    STANDBY <= 1'b1;
    @(posedge CORE_CLK);
    STANDBY <= 1'b0;
    rdc("ctrl", `SFC_OFS_CTRL, 32'h0);
  endtask
  task automatic t_tx();
    logic [7:0]  fs [6] = '{8'h00, 8'h48, 8'h20, 8'h30, 8'h24, 8'h24};
    logic        ms [6] = '{0, 0, 0, 0, 1, 0};
    logic [7:0]  ds [6] = '{8'hA5, 8'hD3, 8'h5C, 8'h5C, 8'h81, 8'h81};
    logic [11:0] x, g;
    int          k;
    // After a reset the rate counter runs out its old reload once.
    wr(`SFC_OFS_RATE, 32'h0);
    repeat (256) @(posedge CORE_CLK);
    for (int i = 0; i < 6; i++)
    begin
      cfg(fs[i], ms[i], 8'h24);
      wr(`SFC_OFS_TXHOLD, {24'h0, ds[i]});
      x = 12'hFFF;
      k = fs[i][6] ? 7 : 8;
      for (int j = 0; j < k; j++)
        x[j] = ds[i][j];
      if (fs[i][2] && ms[i])
        x[k] = ms[i];
      else if (fs[i][5])
        x[k] = (fs[i][6] ? ^ds[i][6:0] : ^ds[i]) ^ fs[i][4];
      k = k + 2 + ((fs[i][2] && ms[i]) || fs[i][5]) + fs[i][3];
      fork
        peer.grab(k, g);
        wr(`SFC_OFS_FLAG, {31'h0, ms[i]});
      join
      check("frame", {20'h0, g}, {20'h0, {x[10:0], 1'b0} & ((12'h1 << k) - 1)});
      rdc("flag", `SFC_OFS_FLAG, {24'h0, 7'h42, ms[i]});
      check("tx_done_flag_irq", {31'h0, TX_END_IRQ}, 32'h1);
    end
    wr(`SFC_OFS_CTRL, 32'h20);
    settle();
    check("tx_done_flag_irq", {31'h0, TX_END_IRQ}, 32'h0);
  endtask
  task automatic t_presc();
    realtime t;
    int      n;
    for (int c = 0; c < 4; c++)
    begin
      cfg({6'h0, c[1:0]}, 1'b0, 8'h20);
      wr(`SFC_OFS_TXHOLD, 32'hFD);
      fork
        wr(`SFC_OFS_FLAG, 32'h0);
        begin
          // Time the first data bit alone: the start bit's length
          // depends on where the load falls in the prescaler cycle.
          @(negedge tx_wire);
          @(posedge tx_wire);
          t = $realtime;
          @(negedge tx_wire);
          n = int'(($realtime - t) / 5.0);
        end
      join
      check("bit_run", n, 16 << (2 * c));
      repeat (200 << (2 * c)) @(posedge CORE_CLK);
    end
    wr(`SFC_OFS_CTRL, 32'h0);
  endtask
  task automatic t_rx();
    cfg(8'h00, 1'b0, 8'h50);
    rxf(12'h1A5, 9);
    rdc("rxhold", `SFC_OFS_RXHOLD, 32'hA5);
    rdc("flag", `SFC_OFS_FLAG, 32'hC4);
    check("rxf_irq", {31'h0, RX_FULL_IRQ}, 32'h1);
    wr(`SFC_OFS_CTRL, 32'h10);
    settle();
    check("rxf_irq", {31'h0, RX_FULL_IRQ}, 32'h0);
    wr(`SFC_OFS_FLAG, 32'h80);
    cfg(8'h08, 1'b0, 8'h50);
    @(posedge CORE_CLK);
    peer.send(12'h13C, 9);
    rxf(12'h3C3, 10);
    rdc("rxhold", `SFC_OFS_RXHOLD, 32'h3C);
    rdc("flag", `SFC_OFS_FLAG, 32'hE4);
    check("err_irq", {31'h0, RX_ERROR_IRQ}, 32'h1);
    for (int i = 0; i < 2; i++)
    begin
      wr(`SFC_OFS_FLAG, 32'h80);
      cfg(i ? 8'h30 : 8'h20, 1'b0, 8'h10);
      rxf(12'h201, 10);
      rdc("flag", `SFC_OFS_FLAG, i ? 32'hC4 : 32'h8C);
    end
    wr(`SFC_OFS_FLAG, 32'h80);
    cfg(8'h04, 1'b1, 8'h58);
    rxf(12'h211, 10);
    rdc("flag", `SFC_OFS_FLAG, 32'h84);
    rdc("rxhold", `SFC_OFS_RXHOLD, 32'h01);
    check("rxf_irq", {31'h0, RX_FULL_IRQ}, 32'h0);
    rxf(12'h322, 10);
    rdc("rxhold", `SFC_OFS_RXHOLD, 32'h22);
    rdc("flag", `SFC_OFS_FLAG, 32'hC6);
    rdc("ctrl", `SFC_OFS_CTRL, 32'h50);
    wr(`SFC_OFS_FLAG, 32'h80);
    rxf(12'h233, 10);
    rdc("rxhold", `SFC_OFS_RXHOLD, 32'h33);
    for (int i = 0; i < 2; i++)
    begin
      wr(`SFC_OFS_FLAG, 32'h80);
      cfg(i ? 8'h04 : 8'h00, !i[0], 8'h58);
      rxf(i ? 12'h155 : 12'h144, 9);
      rdc("rxhold", `SFC_OFS_RXHOLD, i ? 32'h55 : 32'h44);
    end
  endtask
  task automatic close_out();
    if (fail_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge CORE_CLK);
    SYS_RST <= 1'b0;
    t_regs();
    t_tx();
    t_presc();
    t_rx();
    close_out();
  end
  // Longest path is the divide-by-64 frame; this leaves ample margin.
  initial
  begin
    #300000;
    fail_count++;
    close_out();
  end
endmodule // tb
`default_nettype wire
